//--- tec_pkg.sv
// package: register map, field positions, reset values and types of the event timer
`default_nettype none
package tec_pkg;
  // register byte offsets
  localparam logic [5:0] OFF_ENABLE  = 6'h00;
  localparam logic [5:0] OFF_RUN     = 6'h04;
  localparam logic [5:0] OFF_START   = 6'h08;
  localparam logic [5:0] OFF_MODE    = 6'h0c;
  localparam logic [5:0] OFF_FFCTL   = 6'h10;
  localparam logic [5:0] OFF_STATUS  = 6'h14;
  localparam logic [5:0] OFF_MASK    = 6'h18;
  localparam logic [5:0] OFF_LIVE    = 6'h1c;
  localparam logic [5:0] OFF_CMP0    = 6'h20;
  localparam logic [5:0] OFF_CMP1    = 6'h24;
  localparam logic [5:0] OFF_CAP0    = 6'h28;
  localparam logic [5:0] OFF_CAP1    = 6'h2c;
  // field positions
  localparam int BIT_UNIT_EN   = 7;
  localparam int BIT_HALT_STOP = 6;
  localparam int BIT_PRE_RUN   = 2;
  localparam int BIT_CNT_RUN   = 0;
  localparam int BIT_DBUF      = 7;
  localparam int BIT_SYNC      = 5;
  localparam int BIT_IDLE_OP   = 3;
  localparam int BIT_TRG_EDGE  = 1;
  localparam int BIT_START_SRC = 0;
  localparam int BIT_CPM_LO    = 8;
  localparam int BIT_SOFT_CAP  = 6;
  localparam int BIT_CLR_EN    = 3;
  localparam int BIT_TOG_CAP1  = 5;
  localparam int BIT_TOG_CAP0  = 4;
  localparam int BIT_TOG_MAT1  = 3;
  localparam int BIT_TOG_MAT0  = 2;
  localparam int BIT_ST_OVF    = 2;
  localparam int BIT_ST_MAT1   = 1;
  localparam int BIT_ST_MAT0   = 0;
  // reset values, fixed read fields and prescaler width
  localparam logic [15:0] CNT_RESET    = 16'h0000;
  localparam logic [1:0]  FFCTL_HI_RD  = 2'h3;
  localparam logic [1:0]  FFCMD_RD     = 2'h3;
  localparam int          PRE_WIDTH    = 8;
  // capture modes
  localparam logic [2:0] CPM_OFF     = 3'h0;
  localparam logic [2:0] CPM_IN01    = 3'h1;
  localparam logic [2:0] CPM_IN0RF   = 3'h2;
  localparam logic [2:0] CPM_FF      = 3'h3;
  localparam logic [2:0] CPM_CLR1    = 3'h4;
  localparam logic [2:0] CPM_CAP_CLR = 3'h5;
  // flip-flop commands
  localparam logic [1:0] FF_INVERT = 2'h0;
  localparam logic [1:0] FF_SET    = 2'h1;
  localparam logic [1:0] FF_CLEAR  = 2'h2;
  // external pins sampled together
  typedef struct packed {
    logic count_in;   // external_count_input
    logic cap_in0;    // capture_input_0
    logic cap_in1;    // capture_input_1
    logic dbg_halt;   // debugger halt state
    logic idle;       // low-power idle state
    logic sync_run;   // master channel running, for synchronous start
  } tec_pins_s;
  // whole state of the timer
  typedef struct packed {
    logic        unit_en;     // unit_clock_enable
    logic        halt_stop;   // debug_halt_stop
    logic        pre_run;     // prescaler_run
    logic        cnt_run;     // counter_run
    logic        dbuf;        // compare_double_buffer
    logic        sync_sel;    // sync_start_select
    logic        idle_op;     // idle_operation
    logic        trg_edge;    // trigger_edge_select
    logic        start_src;   // start_source_select
    logic [2:0]  cpm;         // capture_mode
    logic        clr_en;      // match_clear_enable
    logic [2:0]  clk_sel;     // source_clock_select
    logic [3:0]  tog_en;      // toggle enables cap1,cap0,mat1,mat0
    logic [2:0]  st;          // event status flags
    logic [2:0]  im;          // event mask
    logic [15:0] cnt;         // up-counter
    logic [15:0] cmp0;        // active compare 0
    logic [15:0] cmp1;        // active compare 1
    logic [15:0] cmp0_buf;    // written compare 0
    logic [15:0] cmp1_buf;    // written compare 1
    logic [15:0] cap0;        // capture register 0
    logic [15:0] cap1;        // capture register 1
    logic [7:0]  pre;         // prescaler
    logic        started;     // trigger seen, counting allowed
    logic        ff;          // timer_flipflop_out
    logic        ff_prev;     // previous flip-flop for edge capture
    tec_pins_s   pins_prev;   // previous pins for edge detection
    logic        irq;         // timer_interrupt
    logic        wait_req;    // waitrequest
    logic [31:0] rdata;       // readdata
    logic        busy;        // answer being given
  } tec_state_s;
endpackage : tec_pkg
`default_nettype wire

//--- tec_timer.sv
// event timer: 16-bit up-counter with prescaler, compares, captures and flip-flop
// Operation
// - one counter, two compares, captures, flip-flop
// - unit disabled freezes and blocks other registers
// - settings kept while unit disabled
// - debug-halt bit stops timer while halted
// - prescaler run bit; zero stops, clears
// - counter run bit; zero stops, clears
// - double-buffer bit buffers compare registers
// - sync bit follows master channel run
// - idle bit keeps timer running in idle
// - start source and trigger edge select
// - capture modes off, in0/in1, in0 both
// - mode 011 captures on flip-flop edges
// - modes 100/101 clear on input 1 rise
// - capture before clear on same cycle
// - writing zero soft-captures; reads as one
// - match-clear bit clears on compare 1
// - source clock pin or prescaler taps
// - toggle flip-flop on enabled captures
// - toggle flip-flop on enabled matches
// - flip-flop command field; reads as 11
// - trigger start waits for selected edge
// - overflow sets flag and interrupt
// - status read clears; flags ignore mask
//
// Chosen here: register access over Avalon-MM.
`default_nettype none
module tec_timer #(
  parameter int CNT_W = 16  // counter width
) (
  input  wire logic             ref_clk,
  input  wire logic             rst_n,
  input  wire logic [5:0]       avs_address,
  input  wire logic             avs_read,
  input  wire logic             avs_write,
  input  wire logic [31:0]      avs_writedata,
  input  wire logic [3:0]       avs_byteenable,
  output logic      [31:0]      avs_readdata,
  output logic                  avs_waitrequest,
  input  wire tec_pkg::tec_pins_s pins,
  output logic                  timer_flipflop_out,
  output logic                  timer_interrupt
);

  // registered state: counter, compares, captures and flip-flop all live here
  tec_pkg::tec_state_s s_q;
  tec_pkg::tec_state_s s_d;  // next state

  // prescaler tap enable: true when the low tap bits of the prescaler are all ones
  function automatic logic tap_hit(input logic [7:0] pre, input logic [2:0] sel);
    logic hit;
    hit = 1'b0;
    unique case (sel)
      3'h1: hit = 1'b1;
      3'h2: hit = &pre[1:0];
      3'h3: hit = &pre[3:0];
      3'h4: hit = &pre[4:0];
      3'h5: hit = &pre[5:0];
      3'h6: hit = &pre[6:0];
      3'h7: hit = &pre[7:0];
      default: hit = 1'b0;
    endcase
    return hit;
  endfunction : tap_hit

  // answer-phase access strobes; the slave answers one cycle after a request
  logic        acc;       // request sampled this cycle, answer due
  logic        wr_go;     // write takes effect now
  logic [2:0]  st_set;    // status flags raised by events this cycle
  logic        gated;     // unit disabled: other registers inert
  logic        run_ok;    // not frozen by halt or idle
  logic        tick;      // one count clock enable
  logic        ext_rise;  // count pin rising edge
  logic        trg_edge;  // selected start trigger edge
  logic        in0_r;     // input 0 rising
  logic        in0_f;     // input 0 falling
  logic        in1_r;     // input 1 rising
  logic        ff_r;      // flip-flop rising
  logic        ff_f;      // flip-flop falling
  logic        cap0_ev;   // capture into register 0
  logic        cap1_ev;   // capture into register 1
  logic        mat0;      // match compare 0
  logic        mat1;      // match compare 1
  logic        in1_clr;   // input 1 clears counter
  logic        go;        // counter enabled to count
  logic [31:0] rd_val;    // read mux value

  // combinational next state of the whole timer
  always_comb begin
    s_d      = s_q;
    acc      = (avs_read || avs_write) && !s_q.busy;
    wr_go    = avs_write && s_q.busy;
    st_set   = 3'h0;
    gated    = !s_q.unit_en;
    run_ok   = !(pins.dbg_halt && s_q.halt_stop) && !(pins.idle && !s_q.idle_op);
    // edge detectors on sampled pins
    ext_rise = pins.count_in && !s_q.pins_prev.count_in;
    trg_edge = s_q.trg_edge ? (!pins.count_in && s_q.pins_prev.count_in) : ext_rise;
    in0_r    = pins.cap_in0 && !s_q.pins_prev.cap_in0;
    in0_f    = !pins.cap_in0 && s_q.pins_prev.cap_in0;
    in1_r    = pins.cap_in1 && !s_q.pins_prev.cap_in1;
    ff_r     = s_q.ff && !s_q.ff_prev;
    ff_f     = !s_q.ff && s_q.ff_prev;
    cap0_ev  = 1'b0;
    cap1_ev  = 1'b0;
    in1_clr  = 1'b0;
    // capture source by mode; reserved codes do nothing
    unique case (s_q.cpm)
      tec_pkg::CPM_IN01: begin
        cap0_ev = in0_r;
        cap1_ev = in1_r;
      end
      tec_pkg::CPM_IN0RF: begin
        cap0_ev = in0_r;
        cap1_ev = in0_f;
      end
      tec_pkg::CPM_FF: begin
        cap0_ev = ff_r;
        cap1_ev = ff_f;
      end
      tec_pkg::CPM_CLR1: in1_clr = in1_r;
      tec_pkg::CPM_CAP_CLR: begin
        cap0_ev = in0_r;
        in1_clr = in1_r;
      end
      default: ;
    endcase
    // soft capture: writing zero to the capture bit of the mode register
    if (wr_go && !gated && avs_address == tec_pkg::OFF_MODE && avs_byteenable[0]
        && !avs_writedata[tec_pkg::BIT_SOFT_CAP]) begin
      cap0_ev = 1'b1;
    end
    // a disabled unit freezes every event source
    if (gated) begin
      cap0_ev = 1'b0;
      cap1_ev = 1'b0;
      in1_clr = 1'b0;
    end
    // synchronous mode follows the master; otherwise own run bit and trigger
    go       = s_q.sync_sel ? pins.sync_run : (s_q.cnt_run && s_q.started);
    tick     = (s_q.clk_sel == 3'h0) ? ext_rise
               : (s_q.pre_run && tap_hit(s_q.pre, s_q.clk_sel));
    mat0     = go && (s_q.cnt == s_q.cmp0);
    mat1     = go && (s_q.cnt == s_q.cmp1);

    if (!gated && run_ok) begin
      // prescaler free-runs while enabled, clears when stopped
      s_d.pre = s_q.pre_run ? s_q.pre + 8'h01 : 8'h00;
      // trigger wait: counting starts on the chosen edge
      if (!s_q.cnt_run) begin
        s_d.started = 1'b0;
      end else if (!s_q.start_src || trg_edge) begin
        s_d.started = 1'b1;
      end
      // captures store the pre-clear count
      if (cap0_ev) begin
        s_d.cap0 = s_q.cnt;
      end
      if (cap1_ev) begin
        s_d.cap1 = s_q.cnt;
      end
      // counter: stop-clear, match or pin clear, else count on tick
      if (!go && !s_q.sync_sel) begin
        s_d.cnt = tec_pkg::CNT_RESET;
      end else if (in1_clr || (mat1 && s_q.clr_en && tick)) begin
        s_d.cnt = tec_pkg::CNT_RESET;
      end else if (go && tick) begin
        s_d.cnt = s_q.cnt + 16'h0001;
        if (s_q.cnt == 16'hffff) begin
          st_set[tec_pkg::BIT_ST_OVF] = 1'b1;
        end
      end
      // match flags latch regardless of mask
      if (mat0 && tick) begin
        st_set[tec_pkg::BIT_ST_MAT0] = 1'b1;
      end
      if (mat1 && tick) begin
        st_set[tec_pkg::BIT_ST_MAT1] = 1'b1;
      end
      // double buffer reloads active compares when the cycle restarts
      if (s_q.dbuf && (s_d.cnt == tec_pkg::CNT_RESET) && s_q.cnt != tec_pkg::CNT_RESET) begin
        s_d.cmp0 = s_q.cmp0_buf;
        s_d.cmp1 = s_q.cmp1_buf;
      end
      // flip-flop toggles on enabled events
      if ((cap1_ev && s_q.tog_en[3]) ^ (cap0_ev && s_q.tog_en[2])
          ^ (mat1 && tick && s_q.tog_en[1]) ^ (mat0 && tick && s_q.tog_en[0])) begin
        s_d.ff = !s_q.ff;
      end
    end
    s_d.ff_prev   = s_q.ff;
    s_d.pins_prev = pins;

    // bus: one wait cycle, then answer; waitrequest is high except on the answer cycle
    s_d.busy     = acc;
    s_d.wait_req = !acc;
    s_d.rdata    = 32'h0000_0000;
    rd_val       = 32'h0000_0000;
    if (acc && avs_read) begin
      unique case (avs_address)
        tec_pkg::OFF_ENABLE: begin
          rd_val[tec_pkg::BIT_UNIT_EN]   = s_q.unit_en;
          rd_val[tec_pkg::BIT_HALT_STOP] = s_q.halt_stop;
        end
        tec_pkg::OFF_RUN: begin
          rd_val[tec_pkg::BIT_PRE_RUN] = s_q.pre_run;
          rd_val[tec_pkg::BIT_CNT_RUN] = s_q.cnt_run;
        end
        tec_pkg::OFF_START: begin
          rd_val[tec_pkg::BIT_DBUF]      = s_q.dbuf;
          rd_val[tec_pkg::BIT_SYNC]      = s_q.sync_sel;
          rd_val[tec_pkg::BIT_IDLE_OP]   = s_q.idle_op;
          rd_val[tec_pkg::BIT_TRG_EDGE]  = s_q.trg_edge;
          rd_val[tec_pkg::BIT_START_SRC] = s_q.start_src;
        end
        tec_pkg::OFF_MODE: begin
          rd_val[tec_pkg::BIT_CPM_LO+:3] = s_q.cpm;
          rd_val[tec_pkg::BIT_SOFT_CAP]  = 1'b1;
          rd_val[tec_pkg::BIT_CLR_EN]    = s_q.clr_en;
          rd_val[2:0]                    = s_q.clk_sel;
        end
        tec_pkg::OFF_FFCTL: rd_val[7:0] = {tec_pkg::FFCTL_HI_RD, s_q.tog_en,
                                           tec_pkg::FFCMD_RD};
        tec_pkg::OFF_STATUS: rd_val[2:0] = s_q.st;
        tec_pkg::OFF_MASK:   rd_val[2:0] = s_q.im;
        tec_pkg::OFF_LIVE:   rd_val[15:0] = s_q.cnt;
        tec_pkg::OFF_CMP0:   rd_val[15:0] = s_q.cmp0_buf;
        tec_pkg::OFF_CMP1:   rd_val[15:0] = s_q.cmp1_buf;
        tec_pkg::OFF_CAP0:   rd_val[15:0] = s_q.cap0;
        tec_pkg::OFF_CAP1:   rd_val[15:0] = s_q.cap1;
        default:             rd_val = 32'h0000_0000;
      endcase
      // a disabled unit answers zero for all but the enable register
      s_d.rdata = (gated && avs_address != tec_pkg::OFF_ENABLE) ? 32'h0000_0000 : rd_val;
    end
    // reading status clears it on the edge that samples it, so no event slips
    // between sample and clear; an event in the same cycle wins
    s_d.st = s_q.st | st_set;
    if (acc && avs_read && !gated && avs_address == tec_pkg::OFF_STATUS) begin
      s_d.st = st_set;
    end

    // register writes; settings persist while disabled
    if (wr_go && avs_byteenable[0]) begin
      if (avs_address == tec_pkg::OFF_ENABLE) begin
        s_d.unit_en   = avs_writedata[tec_pkg::BIT_UNIT_EN];
        s_d.halt_stop = avs_writedata[tec_pkg::BIT_HALT_STOP];
      end else if (!gated) begin
        unique case (avs_address)
          tec_pkg::OFF_RUN: begin
            s_d.pre_run = avs_writedata[tec_pkg::BIT_PRE_RUN];
            s_d.cnt_run = avs_writedata[tec_pkg::BIT_CNT_RUN];
          end
          tec_pkg::OFF_START: begin
            s_d.dbuf      = avs_writedata[tec_pkg::BIT_DBUF];
            s_d.sync_sel  = avs_writedata[tec_pkg::BIT_SYNC];
            s_d.idle_op   = avs_writedata[tec_pkg::BIT_IDLE_OP];
            s_d.trg_edge  = avs_writedata[tec_pkg::BIT_TRG_EDGE];
            s_d.start_src = avs_writedata[tec_pkg::BIT_START_SRC];
          end
          tec_pkg::OFF_MODE: begin
            s_d.clr_en  = avs_writedata[tec_pkg::BIT_CLR_EN];
            s_d.clk_sel = avs_writedata[2:0];
          end
          tec_pkg::OFF_FFCTL: begin
            s_d.tog_en = avs_writedata[5:2];
            unique case (avs_writedata[1:0])
              tec_pkg::FF_INVERT: s_d.ff = !s_q.ff;
              tec_pkg::FF_SET:    s_d.ff = 1'b1;
              tec_pkg::FF_CLEAR:  s_d.ff = 1'b0;
              default: ;
            endcase
          end
          tec_pkg::OFF_MASK: s_d.im = avs_writedata[2:0];
          tec_pkg::OFF_CMP0: begin
            s_d.cmp0_buf[7:0] = avs_writedata[7:0];
            if (!s_q.dbuf) s_d.cmp0[7:0] = avs_writedata[7:0];
          end
          tec_pkg::OFF_CMP1: begin
            s_d.cmp1_buf[7:0] = avs_writedata[7:0];
            if (!s_q.dbuf) s_d.cmp1[7:0] = avs_writedata[7:0];
          end
          default: ;
        endcase
      end
    end
    if (wr_go && avs_byteenable[1] && !gated) begin
      if (avs_address == tec_pkg::OFF_MODE) begin
        s_d.cpm = avs_writedata[tec_pkg::BIT_CPM_LO+:3];
      end else if (avs_address == tec_pkg::OFF_CMP0) begin
        s_d.cmp0_buf[15:8] = avs_writedata[15:8];
        if (!s_q.dbuf) s_d.cmp0[15:8] = avs_writedata[15:8];
      end else if (avs_address == tec_pkg::OFF_CMP1) begin
        s_d.cmp1_buf[15:8] = avs_writedata[15:8];
        if (!s_q.dbuf) s_d.cmp1[15:8] = avs_writedata[15:8];
      end
    end
    // interrupt from unmasked flags of the next state
    s_d.irq = |(s_d.st & s_d.im);
  end

  // state register; synchronous reset to documented values
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      s_q          <= '0;
      s_q.wait_req <= 1'b1;
    end else begin
      s_q <= s_d;
    end
  end

  assign avs_readdata       = s_q.rdata;
  assign avs_waitrequest    = s_q.wait_req;
  assign timer_flipflop_out = s_q.ff;
  assign timer_interrupt    = s_q.irq;

  // counter stopped by run bit reads zero next cycle
  a_run_clear_cnt: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (s_q.unit_en && !s_q.cnt_run && !s_q.sync_sel && run_ok) |=> s_q.cnt == 16'h0000)
    else $error("counter not cleared while stopped");
  // prescaler stopped clears
  a_pre_stop_clr: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (s_q.unit_en && !s_q.pre_run && run_ok) |=> s_q.pre == 8'h00)
    else $error("prescaler not cleared");
  // disabled unit holds the counter
  a_gate_hold: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (!s_q.unit_en && !s_d.unit_en) |=> $stable(s_q.cnt) && $stable(s_q.cap0))
    else $error("counter moved while unit disabled");
  // overflow sets status
  a_ovf_flag: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (s_q.unit_en && run_ok && go && tick && s_q.cnt == 16'hffff && !in1_clr
     && !(mat1 && s_q.clr_en)) |=> s_q.st[2])
    else $error("overflow flag missing");
  // capture takes the count of that cycle
  a_cap0_value: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (!gated && run_ok && cap0_ev) |=> s_q.cap0 == $past(s_q.cnt))
    else $error("capture 0 value wrong");
  // trigger mode waits for edge
  a_trig_wait: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (s_q.unit_en && run_ok && s_q.start_src && !s_q.started && !trg_edge)
    |=> !s_q.started)
    else $error("started without trigger");
  // match clear returns count to zero
  a_match_clr: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (!gated && run_ok && mat1 && s_q.clr_en && tick) |=> s_q.cnt == 16'h0000)
    else $error("match clear missed");
  // flip-flop set command
  a_ff_set: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (wr_go && !gated && avs_byteenable[0] && avs_address == tec_pkg::OFF_FFCTL
     && avs_writedata[1:0] == tec_pkg::FF_SET) |=> timer_flipflop_out)
    else $error("flip-flop not set");
  // answer comes on the second cycle of a request
  a_bus_answer: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (acc) |=> !avs_waitrequest ##1 avs_waitrequest)
    else $error("bus answer timing wrong");

endmodule : tec_timer
`default_nettype wire

//--- tec_pin_model.sv
// partner model: the timer's external pins, driven on the bench's command
`default_nettype none
module tec_pin_model (
  input  wire logic       ref_clk,   // system clock
  input  wire logic       rst_n,     // synchronous reset, active low
  input  wire logic       count_en,  // let the external count clock run
  input  wire logic [1:0] cap,       // capture input levels, input 1 then input 0
  output var tec_pkg::tec_pins_s pins // pins as the timer sees them
);
  timeunit 1ns;
  timeprecision 1ns;
  logic cnt_pin_q;  // external count clock level
  // count pin rests low outside a burst so no stray edge is counted
  always_ff @(posedge ref_clk) begin
    if (!rst_n || !count_en) cnt_pin_q <= 1'b0;
    else cnt_pin_q <= !cnt_pin_q;
  end
  // halt, idle and master-run stay inactive: this bench runs one channel only
  assign pins = '{count_in: cnt_pin_q, cap_in0: cap[0], cap_in1: cap[1], default: 1'b0};
endmodule : tec_pin_model
`default_nettype wire

//--- tb.sv
// testbench: register bus, counting, match, flip-flop and capture of the event timer
`default_nettype none
module tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic ref_clk, rst_n, avs_read, avs_write, avs_waitrequest, count_en;
  logic timer_flipflop_out, timer_interrupt;
  logic [5:0]  avs_address;
  logic [31:0] avs_writedata, avs_readdata, rd, prev;
  logic [1:0]  cap;
  tec_pkg::tec_pins_s pins;
  int n_mismatch, n_tests;
  tec_timer uut (.ref_clk, .rst_n, .avs_address, .avs_read, .avs_write, .avs_writedata,
    .avs_byteenable(4'hf), .avs_readdata, .avs_waitrequest, .pins, .timer_flipflop_out,
    .timer_interrupt);
  tec_pin_model pm (.ref_clk, .rst_n, .count_en, .cap, .pins);
  // 100 ns clock
  initial begin
    ref_clk = 1'b0;
    forever #50 ref_clk = ~ref_clk;
  end
  // one compare for every kind of result
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      n_mismatch++;
      $display("mismatch at %0t: got %h want %h", $time, got, exp);
    end
  endtask : chk
  // one bus access; a dead cycle first so no signal is driven twice in one step
  task automatic bus(input logic [5:0] a, input logic w, input logic [31:0] d);
    @(posedge ref_clk);
    avs_address <= a;
    avs_write <= w;
    avs_read <= !w;
    avs_writedata <= d;
    // no cycle count assumed: only the watchdog ends a hung wait
    do begin
      @(posedge ref_clk);
    end while (avs_waitrequest !== 1'b0);
    rd = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask : bus
  task automatic summarize();
    $display("counts: %0d compares, %0d mismatches", n_tests, n_mismatch);
    if (n_mismatch == 0 && n_tests > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : summarize
  // blocked while disabled, then reset values once enabled
  task automatic t_regs();
    bus(tec_pkg::OFF_CMP0, 1, 32'h1234);
    bus(tec_pkg::OFF_FFCTL, 0, 0); chk(rd, 32'h0);
    bus(tec_pkg::OFF_ENABLE, 1, 32'h80);
    bus(tec_pkg::OFF_ENABLE, 0, 0); chk(rd, 32'h80);
    bus(tec_pkg::OFF_CMP0, 0, 0); chk(rd, 32'h0);
    bus(tec_pkg::OFF_FFCTL, 0, 0); chk(rd, 32'hc3);
    bus(tec_pkg::OFF_MODE, 0, 0); chk(rd, 32'h40);
    bus(6'h30, 0, 0); chk(rd, 32'h0);
    $display("test regs done");
  endtask : t_regs
  // external pin as count clock, then stop clears
  task automatic t_pin();
    bus(tec_pkg::OFF_MODE, 1, 32'h0);
    bus(tec_pkg::OFF_RUN, 1, 32'h1);
    repeat (10) @(posedge ref_clk);
    bus(tec_pkg::OFF_LIVE, 0, 0); chk(rd, 32'h0);
    count_en <= 1'b1;
    repeat (20) @(posedge ref_clk);
    count_en <= 1'b0;
    bus(tec_pkg::OFF_LIVE, 0, 0); chk(rd, 32'h0000_000a);
    bus(tec_pkg::OFF_RUN, 1, 32'h0);
    bus(tec_pkg::OFF_LIVE, 0, 0); chk(rd, 32'h0);
    $display("test pin done");
  endtask : t_pin
  // match on compare 1 clears the count and raises the unmasked flag
  task automatic t_match();
    int k;
    bus(tec_pkg::OFF_CMP1, 1, 32'h10);
    bus(tec_pkg::OFF_MODE, 1, 32'h09);
    bus(tec_pkg::OFF_MASK, 1, 32'h2);
    bus(tec_pkg::OFF_RUN, 1, 32'h5);
    for (k = 0; k < 200 && timer_interrupt !== 1'b1; k++) @(posedge ref_clk);
    chk({31'h0, timer_interrupt}, 32'h1);
    bus(tec_pkg::OFF_LIVE, 0, 0); chk({31'h0, rd <= 32'h10}, 32'h1);
    bus(tec_pkg::OFF_RUN, 1, 32'h0);
    bus(tec_pkg::OFF_STATUS, 0, 0); chk({31'h0, rd[1]}, 32'h1);
    bus(tec_pkg::OFF_STATUS, 0, 0); chk({31'h0, rd[1]}, 32'h0);
    chk({31'h0, timer_interrupt}, 32'h0);
    $display("test match done");
  endtask : t_match
  // every flip-flop command, timer stopped
  task automatic t_ff();
    logic [1:0] cmd[4] = '{2'h1, 2'h2, 2'h0, 2'h0};
    logic       exp[4] = '{1'b1, 1'b0, 1'b1, 1'b0};
    foreach (cmd[i]) begin
      bus(tec_pkg::OFF_FFCTL, 1, {30'h0, cmd[i]});
      @(posedge ref_clk);
      chk({31'h0, timer_flipflop_out}, {31'h0, exp[i]});
    end
    $display("test ff done");
  endtask : t_ff
  // input capture, soft capture, settings kept across disable
  task automatic t_cap();
    bus(tec_pkg::OFF_MODE, 1, 32'h141);
    bus(tec_pkg::OFF_RUN, 1, 32'h5);
    repeat (30) @(posedge ref_clk);
    cap <= 2'b01;
    repeat (3) @(posedge ref_clk);
    bus(tec_pkg::OFF_CAP0, 0, 0); chk({31'h0, rd != 0}, 32'h1);
    prev = rd;
    bus(tec_pkg::OFF_MODE, 1, 32'h101);
    bus(tec_pkg::OFF_CAP0, 0, 0); chk({31'h0, rd > prev}, 32'h1);
    bus(tec_pkg::OFF_RUN, 1, 32'h0);
    bus(tec_pkg::OFF_ENABLE, 1, 32'h0);
    bus(tec_pkg::OFF_ENABLE, 1, 32'h80);
    bus(tec_pkg::OFF_CMP1, 0, 0); chk(rd, 32'h10);
    $display("test cap done");
  endtask : t_cap
  // external trigger start waits for the pin edge; match 1 toggles the flip-flop
  task automatic t_trig();
    bus(tec_pkg::OFF_START, 1, 32'h1);
    bus(tec_pkg::OFF_MODE, 1, 32'h41);
    bus(tec_pkg::OFF_FFCTL, 1, 32'ha);
    bus(tec_pkg::OFF_RUN, 1, 32'h5);
    repeat (10) @(posedge ref_clk);
    bus(tec_pkg::OFF_LIVE, 0, 0); chk(rd, 32'h0);
    count_en <= 1'b1;
    repeat (2) @(posedge ref_clk);
    count_en <= 1'b0;
    repeat (40) @(posedge ref_clk);
    chk({31'h0, timer_flipflop_out}, 32'h1);
    bus(tec_pkg::OFF_LIVE, 0, 0); chk({31'h0, rd != 0}, 32'h1);
    bus(tec_pkg::OFF_RUN, 1, 32'h0);
    bus(tec_pkg::OFF_START, 1, 32'h0);
    $display("test trig done");
  endtask : t_trig
  // input 0 captures and input 1 clears in the same cycle
  task automatic t_clr();
    cap <= 2'b00;
    bus(tec_pkg::OFF_MODE, 1, 32'h541);
    bus(tec_pkg::OFF_RUN, 1, 32'h5);
    repeat (30) @(posedge ref_clk);
    cap <= 2'b11;
    @(posedge ref_clk);
    bus(tec_pkg::OFF_CAP0, 0, 0); chk({31'h0, rd > 32'h10}, 32'h1);
    prev = rd;
    bus(tec_pkg::OFF_LIVE, 0, 0); chk({31'h0, rd < prev}, 32'h1);
    bus(tec_pkg::OFF_RUN, 1, 32'h0);
    $display("test clr done");
  endtask : t_clr
  // watchdog well beyond the few hundred cycles the tests need
  initial begin
    #3000000;
    n_mismatch++;
    $display("mismatch at %0t: watchdog", $time);
    summarize();
  end
  // main sequence
  initial begin
    {avs_read, avs_write, count_en, rst_n} = '0;
    avs_address = '0;
    avs_writedata = '0;
    cap = '0;
    repeat (2) @(posedge ref_clk);
    rst_n <= 1'b1;
    t_regs();
    t_pin();
    t_match();
    t_ff();
    t_cap();
    t_trig();
    t_clr();
    summarize();
  end
endmodule : tb
`default_nettype wire
